// ===== design/utx_baud.sv
// Baud generator that forms the falling and rising edges of the transfer clock.
`timescale 1ns/1ns
module utx_baud #(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Control
	input  wire logic             tick,
	input  wire logic             restart,
	input  wire logic [CNT_W-1:0] limit,
	// Transfer clock edges
	output logic                  fall,
	output logic                  rise
);
	logic [CNT_W-1:0] cnt_reg;

	// The period is limit plus one ticks; the rising edge sits half way.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_reg <= '0;
		else if (restart)
			cnt_reg <= '0;
		else if (tick)
			cnt_reg <= (cnt_reg == limit) ? '0 : cnt_reg + 1'b1;
	end

	assign fall = tick && !restart && (cnt_reg == limit);
	assign rise = tick && !restart && (cnt_reg == (limit >> 1));
endmodule // utx_baud

// ===== design/utx_engine.sv
// Half-duplex asynchronous serial channel with its register file and port 4 pins.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "utx_map.svh"
module utx_engine (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	// Baud source ticks
	input  wire logic        baud_src_low_tick,
	input  wire logic        baud_src_dbl_tick,
	input  wire logic        baud_src_high_tick,
	// Pins
	input  wire logic        port0_bit2_in,
	input  wire logic [7:0]  port4_in,
	output logic [7:0]       port4_out,
	output logic [7:0]       port4_oe,
	// Channel event
	output logic             serial_irq
);
	// ------------------------------------------------------------
	// Registers and decode
	// ------------------------------------------------------------
	logic [7:0]  serial_mode_reg0;
	logic [7:0]  serial_mode_reg1;
	logic [7:0]  baud_count_low;
	logic [3:0]  baud_count_high;
	logic        channel_enable_bit;
	logic        rx_dir_reg;
	logic [7:0]  shared_txrx_buffer;
	logic        buffer_full_flag;
	logic        unread_reg;
	logic        parity_error_flag;
	logic        overrun_error_flag;
	logic        framing_error_flag;
	logic [7:0]  port4_output_data;
	logic [7:0]  port4_direction;
	logic [7:0]  port4_drive_control_low;
	logic [7:0]  port4_drive_control_high;
	logic [7:0]  port4_function_select_low;
	logic [7:0]  port4_function_select_high;
	logic [7:0]  rdata_reg;
	logic        irq_reg;

	logic        wr_mode0;
	logic        wr_ctl;
	logic        wr_buf;
	logic        wr_stat;
	logic        rd_buf;
	logic        start_go;
	logic        tx_active;
	logic        rx_active;

	assign wr_mode0 = reg_wr && (reg_addr == `UTX_ADDR_MODE0);
	assign wr_ctl   = reg_wr && (reg_addr == `UTX_ADDR_CONTROL);
	assign wr_buf   = reg_wr && (reg_addr == `UTX_ADDR_BUFFER);
	assign wr_stat  = reg_wr && (reg_addr == `UTX_ADDR_STATUS);
	assign rd_buf   = reg_rd && (reg_addr == `UTX_ADDR_BUFFER);

	assign start_go  = wr_ctl && reg_wdata[`UTX_CTL_ENABLE] && !channel_enable_bit;
	assign tx_active = channel_enable_bit && !rx_dir_reg;
	assign rx_active = channel_enable_bit && rx_dir_reg;

	// ------------------------------------------------------------
	// Frame format
	// ------------------------------------------------------------
	logic [3:0]  data_len;
	logic        par_en;
	logic        par_odd;
	logic        two_stop;
	logic        msb_first;
	logic        neg_logic;

	// Length field 0 gives eight bits, 3 gives five.
	assign data_len  = `UTX_FULL_LEN - {2'b00, serial_mode_reg1[`UTX_M1_LEN_HI:`UTX_M1_LEN_LO]};
	assign par_en    = serial_mode_reg1[`UTX_M1_PAR_EN];
	assign par_odd   = serial_mode_reg1[`UTX_M1_PAR_ODD];
	assign two_stop  = serial_mode_reg1[`UTX_M1_TWO_STOP];
	assign msb_first = serial_mode_reg1[`UTX_M1_MSB_FIRST];
	assign neg_logic = serial_mode_reg1[`UTX_M1_NEG_LOGIC];

	// ------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------
	logic [11:0] baud_val;
	logic [11:0] baud_limit;
	logic        baud_tick;
	logic        baud_restart;
	logic        baud_fall;
	logic        baud_rise;
	logic        rx_detect;

	assign baud_val   = {baud_count_high, baud_count_low};
	assign baud_limit = (baud_val < `UTX_BAUD_MIN) ? `UTX_BAUD_MIN : baud_val;
	assign baud_tick  = serial_mode_reg0[`UTX_M0_CLK_HI] ? baud_src_high_tick :
		(serial_mode_reg0[`UTX_M0_CLK_LO] ? baud_src_dbl_tick : baud_src_low_tick);
	// Transmit restarts at enable; receive restarts at the start edge.
	assign baud_restart = start_go || rx_detect;

	utx_baud #(
		.CNT_W   (12)
	) u_baud (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (baud_tick),
		.restart (baud_restart),
		.limit   (baud_limit),
		.fall    (baud_fall),
		.rise    (baud_rise)
	);

	// ------------------------------------------------------------
	// Channel enable and direction
	// ------------------------------------------------------------
	logic tx_load;
	logic tx_finish;

	// Direction is latched only when the channel turns on, so a later mode
	// write cannot swing a running frame to the other direction.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			channel_enable_bit <= 1'b0;
			rx_dir_reg <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
				channel_enable_bit <= reg_wdata[`UTX_CTL_ENABLE];
			else if (tx_finish)
				channel_enable_bit <= 1'b0;
			if (start_go)
				rx_dir_reg <= serial_mode_reg0[`UTX_M0_DIR];
		end
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	utx_pkg::utx_tx_state_type tx_state;
	logic [7:0] tx_shift;
	logic [3:0] tx_bits;
	logic       tx_par;
	logic       tx_stop_cnt;
	logic       tx_line;
	logic       tx_bit;
	logic       tx_stop_done;

	assign tx_bit       = msb_first ? tx_shift[data_len[2:0] - 3'h1] : tx_shift[0];
	assign tx_stop_done = tx_stop_cnt || !two_stop;
	assign tx_load      = tx_active && baud_fall && ((tx_state == utx_pkg::TX_IDLE) ||
		((tx_state == utx_pkg::TX_STOP) && tx_stop_done && buffer_full_flag));
	assign tx_finish    = tx_active && baud_fall && (tx_state == utx_pkg::TX_STOP) &&
		tx_stop_done && !buffer_full_flag;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_state <= utx_pkg::TX_IDLE;
			tx_shift <= `UTX_RST_BYTE;
			tx_bits <= 4'h0;
			tx_par <= 1'b0;
			tx_stop_cnt <= 1'b0;
			tx_line <= 1'b1;
		end
		else if (!tx_active)
		begin
			tx_state <= utx_pkg::TX_IDLE;
			tx_line <= 1'b1;
		end
		else if (tx_load)
		begin
			tx_shift <= shared_txrx_buffer;
			tx_par <= par_odd;
			tx_line <= 1'b0;
			tx_state <= utx_pkg::TX_START;
		end
		else if (baud_fall)
		begin
			case (tx_state)
				utx_pkg::TX_START, utx_pkg::TX_DATA:
				begin
					if (tx_state == utx_pkg::TX_DATA && tx_bits == data_len)
					begin
						tx_line <= par_en ? tx_par : 1'b1;
						tx_stop_cnt <= 1'b0;
						tx_state <= par_en ? utx_pkg::TX_PARITY : utx_pkg::TX_STOP;
					end
					else
					begin
						tx_line <= tx_bit;
						tx_par <= tx_par ^ tx_bit;
						tx_shift <= msb_first ? (tx_shift << 1) : (tx_shift >> 1);
						tx_bits <= (tx_state == utx_pkg::TX_START) ? 4'h1 : tx_bits + 4'h1;
						tx_state <= utx_pkg::TX_DATA;
					end
				end
				utx_pkg::TX_PARITY:
				begin
					tx_line <= 1'b1;
					tx_stop_cnt <= 1'b0;
					tx_state <= utx_pkg::TX_STOP;
				end
				utx_pkg::TX_STOP:
				begin
					if (!tx_stop_done)
						tx_stop_cnt <= 1'b1;
					else
						tx_state <= utx_pkg::TX_IDLE;
				end
				default:
					tx_state <= utx_pkg::TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	utx_pkg::utx_rx_state_type rx_state;
	logic       rx_pin;
	logic       rx_level;
	logic       rx_prev;
	logic [7:0] rx_shift;
	logic [3:0] rx_bits;
	logic       rx_par_bit;
	logic       rx_ovr_pend;
	logic       rx_store;
	logic       rx_check;
	logic [7:0] rx_data;
	logic       rx_par_err;

	assign rx_level  = rx_pin ^ neg_logic;
	assign rx_detect = rx_active && (rx_state == utx_pkg::RX_IDLE) && rx_prev && !rx_level;
	assign rx_store  = rx_active && baud_fall && (rx_state == utx_pkg::RX_STORE);
	assign rx_check  = rx_active && baud_rise && (rx_state == utx_pkg::RX_STOP);
	// The character sits at the top of the register when shifted in from the left.
	assign rx_data    = msb_first ? (rx_shift & (8'hff >> (`UTX_FULL_LEN - data_len))) :
		(rx_shift >> (`UTX_FULL_LEN - data_len));
	assign rx_par_err = par_en && ((^rx_data ^ rx_par_bit) != par_odd);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rx_prev <= 1'b1;
		else
			rx_prev <= rx_level;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_state <= utx_pkg::RX_IDLE;
			rx_shift <= `UTX_RST_BYTE;
			rx_bits <= 4'h0;
			rx_par_bit <= 1'b0;
			rx_ovr_pend <= 1'b0;
		end
		else if (!rx_active)
			rx_state <= utx_pkg::RX_IDLE;
		else if (rx_detect)
			rx_state <= utx_pkg::RX_START;
		else
		begin
			case (rx_state)
				utx_pkg::RX_START:
					if (baud_rise)
					begin
						rx_bits <= 4'h0;
						// A start level gone by mid-bit was a glitch.
						rx_state <= rx_level ? utx_pkg::RX_IDLE : utx_pkg::RX_DATA;
					end
				utx_pkg::RX_DATA:
					if (baud_rise)
					begin
						rx_shift <= msb_first ? {rx_shift[6:0], rx_level} :
							{rx_level, rx_shift[7:1]};
						rx_bits <= rx_bits + 4'h1;
						if (rx_bits + 4'h1 == data_len)
							rx_state <= par_en ? utx_pkg::RX_PARITY : utx_pkg::RX_STORE;
					end
				utx_pkg::RX_PARITY:
					if (baud_rise)
					begin
						rx_par_bit <= rx_level;
						rx_state <= utx_pkg::RX_STORE;
					end
				utx_pkg::RX_STORE:
					if (baud_fall)
					begin
						rx_ovr_pend <= unread_reg;
						rx_state <= utx_pkg::RX_STOP;
					end
				utx_pkg::RX_STOP:
					if (baud_rise)
						rx_state <= utx_pkg::RX_IDLE;
				default:
					rx_state <= utx_pkg::RX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shared buffer and status flags
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			shared_txrx_buffer <= `UTX_RST_BYTE;
		else if (rx_store)
			shared_txrx_buffer <= rx_data;
		else if (wr_buf && !rx_active)
			shared_txrx_buffer <= reg_wdata;
	end

	// Set wins over every clear in the same cycle.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			buffer_full_flag <= 1'b0;
		else if (wr_buf && !rx_active)
			buffer_full_flag <= 1'b1;
		else if (tx_load || wr_stat || rx_active)
			buffer_full_flag <= 1'b0;
	end

	// The unread mark survives disable so overrun still shows after re-enable.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			unread_reg <= 1'b0;
		else if (rx_store)
			unread_reg <= 1'b1;
		else if (rd_buf)
			unread_reg <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			parity_error_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
			framing_error_flag <= 1'b0;
		end
		else if (rx_check)
		begin
			// A status write in the same cycle still clears the older flags.
			parity_error_flag <= (parity_error_flag && !wr_stat) || rx_par_err;
			overrun_error_flag <= (overrun_error_flag && !wr_stat) || rx_ovr_pend;
			framing_error_flag <= (framing_error_flag && !wr_stat) || !rx_level;
		end
		else if (wr_stat)
		begin
			parity_error_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
			framing_error_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			serial_mode_reg0 <= `UTX_RST_BYTE;
			serial_mode_reg1 <= `UTX_RST_BYTE;
			baud_count_low <= `UTX_RST_BAUD_LOW;
			baud_count_high <= `UTX_RST_BAUD_HIGH;
		end
		else if (reg_wr)
		begin
			if (wr_mode0)
				serial_mode_reg0 <= reg_wdata;
			if (reg_addr == `UTX_ADDR_MODE1)
				serial_mode_reg1 <= reg_wdata;
			if (reg_addr == `UTX_ADDR_BAUD_LOW)
				baud_count_low <= reg_wdata;
			if (reg_addr == `UTX_ADDR_BAUD_HIGH)
				baud_count_high <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			port4_output_data <= `UTX_RST_BYTE;
			port4_direction <= `UTX_RST_BYTE;
			port4_drive_control_low <= `UTX_RST_BYTE;
			port4_drive_control_high <= `UTX_RST_BYTE;
			port4_function_select_low <= `UTX_RST_BYTE;
			port4_function_select_high <= `UTX_RST_BYTE;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`UTX_ADDR_P4_DATA: port4_output_data <= reg_wdata;
				`UTX_ADDR_P4_DIR:  port4_direction <= reg_wdata;
				`UTX_ADDR_P4_CON0: port4_drive_control_low <= reg_wdata;
				`UTX_ADDR_P4_CON1: port4_drive_control_high <= reg_wdata;
				`UTX_ADDR_P4_MOD0: port4_function_select_low <= reg_wdata;
				`UTX_ADDR_P4_MOD1: port4_function_select_high <= reg_wdata;
				default:           port4_output_data <= port4_output_data;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_reg <= `UTX_RST_BYTE;
		else if (reg_rd)
		begin
			case (reg_addr)
				`UTX_ADDR_P4_DATA:    rdata_reg <= port4_output_data;
				`UTX_ADDR_P4_DIR:     rdata_reg <= port4_direction;
				`UTX_ADDR_P4_CON0:    rdata_reg <= port4_drive_control_low;
				`UTX_ADDR_P4_CON1:    rdata_reg <= port4_drive_control_high;
				`UTX_ADDR_P4_MOD0:    rdata_reg <= port4_function_select_low;
				`UTX_ADDR_P4_MOD1:    rdata_reg <= port4_function_select_high;
				`UTX_ADDR_MODE0:      rdata_reg <= serial_mode_reg0;
				`UTX_ADDR_MODE1:      rdata_reg <= serial_mode_reg1;
				`UTX_ADDR_BAUD_LOW:   rdata_reg <= baud_count_low;
				`UTX_ADDR_BAUD_HIGH:  rdata_reg <= {4'h0, baud_count_high};
				`UTX_ADDR_CONTROL:    rdata_reg <= {7'h00, channel_enable_bit};
				`UTX_ADDR_BUFFER:     rdata_reg <= shared_txrx_buffer;
				`UTX_ADDR_STATUS:     rdata_reg <= {4'h0, buffer_full_flag, parity_error_flag,
					overrun_error_flag, framing_error_flag};
				default:              rdata_reg <= 8'h00;
			endcase
		end
		else
			rdata_reg <= 8'h00;
	end

	// One pulse for a start bit, a finished frame or a received character.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			irq_reg <= 1'b0;
		else
			irq_reg <= tx_load || tx_finish || rx_check;
	end

	assign reg_rdata  = rdata_reg;
	assign serial_irq = irq_reg;

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	logic tx_pin_level;
	logic rx_mode;

	// Receive mode follows the latched direction while enabled and the mode bit
	// otherwise, so the transmit line stays high whatever the polarity.
	assign rx_mode      = channel_enable_bit ? rx_dir_reg : serial_mode_reg0[`UTX_M0_DIR];
	assign tx_pin_level = rx_mode ? 1'b1 : (tx_line ^ neg_logic);

	utx_pins u_pins (
		.clk           (clk),
		.rst_n         (rst_n),
		.p4_data       (port4_output_data),
		.p4_dir        (port4_direction),
		.p4_con0       (port4_drive_control_low),
		.p4_con1       (port4_drive_control_high),
		.p4_mod0       (port4_function_select_low),
		.p4_mod1       (port4_function_select_high),
		.tx_level      (tx_pin_level),
		.rx_sel        (serial_mode_reg0[`UTX_M0_RX_SEL]),
		.rx_level      (rx_pin),
		.port4_in      (port4_in),
		.port0_bit2_in (port0_bit2_in),
		.port4_out     (port4_out),
		.port4_oe      (port4_oe)
	);
endmodule // utx_engine

// ===== design/utx_map.svh
// Register offsets, field positions, reset values and counts of the serial channel.
//
// Contract
// - Transmit drives start, data, parity, stop bits.
// - Interrupt when a start bit begins.
// - Buffer write sets full; load clears it.
// - Pending byte: interrupt, next frame follows directly.
// - No pending byte: finish, clear enable, interrupt.
// - Receive mode holds transmit output high.
// - Start detection restarts the transfer clock.
// - Receive samples on mid-bit rising edges.
// - Character stored on following transfer falling edge.
// - Next rising edge: interrupt and error check.
// - Parity, overrun, framing errors set status flags.
// - Reception runs until software clears enable.
// - Port data bits ignored on serial pins; the code does so on transmit pin 3 only.
// - Pin select bit picks receive input pin.
// - Any status write clears all status flags.
// - Unread character plus new one sets overrun.
// - Frame format: length, parity, stops, order, polarity.
// - Baud divider uses value plus one, minimum 8.
`ifndef UTX_MAP_SVH
`define UTX_MAP_SVH

`define UTX_ADDR_P4_DATA     16'hf220
`define UTX_ADDR_P4_DIR      16'hf221
`define UTX_ADDR_P4_CON0     16'hf222
`define UTX_ADDR_P4_CON1     16'hf223
`define UTX_ADDR_P4_MOD0     16'hf224
`define UTX_ADDR_P4_MOD1     16'hf225
`define UTX_ADDR_MODE0       16'hf290
`define UTX_ADDR_MODE1       16'hf291
`define UTX_ADDR_BAUD_LOW    16'hf292
`define UTX_ADDR_BAUD_HIGH   16'hf293
`define UTX_ADDR_CONTROL     16'hf294
`define UTX_ADDR_BUFFER      16'hf295
`define UTX_ADDR_STATUS      16'hf296

`define UTX_M0_DIR           0
`define UTX_M0_CLK_LO        1
`define UTX_M0_CLK_HI        2
`define UTX_M0_RX_SEL        4
`define UTX_M1_LEN_LO        0
`define UTX_M1_LEN_HI        1
`define UTX_M1_PAR_EN        2
`define UTX_M1_PAR_ODD       3
`define UTX_M1_TWO_STOP      4
`define UTX_M1_MSB_FIRST     5
`define UTX_M1_NEG_LOGIC     6
`define UTX_CTL_ENABLE       0
`define UTX_TX_PIN           3
`define UTX_RX_PIN           2

`define UTX_RST_BYTE         8'h00
`define UTX_RST_BAUD_LOW     8'hff
`define UTX_RST_BAUD_HIGH    4'hf
`define UTX_BAUD_MIN         12'h008
`define UTX_FULL_LEN         4'h8

`endif

// ===== design/utx_pins.sv
// Port 4 pin logic with the serial transmit and receive routing.
`timescale 1ns/1ns
`include "utx_map.svh"
module utx_pins (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Port registers
	input  wire logic [7:0] p4_data,
	input  wire logic [7:0] p4_dir,
	input  wire logic [7:0] p4_con0,
	input  wire logic [7:0] p4_con1,
	input  wire logic [7:0] p4_mod0,
	input  wire logic [7:0] p4_mod1,
	// Serial side
	input  wire logic       tx_level,
	input  wire logic       rx_sel,
	output logic            rx_level,
	// Pins
	input  wire logic [7:0] port4_in,
	input  wire logic       port0_bit2_in,
	output logic [7:0]      port4_out,
	output logic [7:0]      port4_oe
);
	genvar i;
	wire logic [7:0] out_next;
	wire logic [7:0] oe_next;

	generate
		for (i = 0; i < 8; i++)
		begin : g_pin
			logic serial_fn;
			logic bit_val;
			logic [1:0] drive;

			assign serial_fn = !p4_mod1[i] && p4_mod0[i];
			// On the transmit pin the serial level replaces the port data bit.
			assign bit_val = (i == `UTX_TX_PIN && serial_fn) ? tx_level : p4_data[i];
			assign drive = {p4_con1[i], p4_con0[i]};

			// Both drive bits set give push-pull; one set gives open drain.
			assign out_next[i] = bit_val;
			assign oe_next[i]  = !p4_dir[i] && ((drive == 2'b11) || ((drive != 2'b00) && !bit_val));
		end
	endgenerate

	// One register for the whole port keeps every output bit in a single process.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			port4_out <= 8'h00;
			port4_oe  <= 8'h00;
		end
		else
		begin
			port4_out <= out_next;
			port4_oe  <= oe_next;
		end
	end

	assign rx_level = rx_sel ? port4_in[`UTX_RX_PIN] : port0_bit2_in;
endmodule // utx_pins

// ===== design/utx_pkg.sv
// Shared state types of the serial channel.
package utx_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} utx_tx_state_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STORE, RX_STOP}
		utx_rx_state_type;
endpackage

// ===== verification/testbench.sv
// Testbench of the serial channel with a line peer.
`timescale 1ns/1ns
module testbench;
	logic        clk;
	logic        rst_n;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [7:0]  port4_out;
	logic [7:0]  port4_oe;
	logic        serial_irq;
	logic        on_p4;
	logic        tx_w;
	logic        rx_w;
	int          err_total;
	int          checks;
	int          cyc;
	int          t [3];
	// A released pin is pulled up, so the peer sees an idle line.
	assign tx_w = port4_oe[3] ? port4_out[3] : 1'b1;
	utx_engine utx_engine_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .baud_src_low_tick(1'b0), .baud_src_dbl_tick(1'b0),
		.baud_src_high_tick(1'b1), .port0_bit2_in(on_p4 | rx_w),
		.port4_in({4'hf, tx_w, rx_w | !on_p4, 2'h3}), .port4_out, .port4_oe, .serial_irq);
	utx_peer utx_peer_inst (.clk, .rx_line(tx_w), .tx_line(rx_w));
	always #20 clk = !clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_total++;
			close_out();
		end
	end
	task automatic same(input logic [15:0] w, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %h expected %h seen %h", w, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [15:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		reg_rd <= 1'b0;
		@(negedge clk);
		same(a, reg_rdata, e);
		@(posedge clk);
	endtask
	task automatic wait_irq(output int v);
		int n;
		n = 0;
		@(negedge clk);
		while (serial_irq !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		same(16'h0001, {7'h00, serial_irq}, 8'h01);
		v = cyc;
		@(posedge clk);
	endtask
	task automatic rx_frame(input logic [10:0] b, input int n);
		fork
			utx_peer_inst.send(b, n);
			wait_irq(t[0]);
		join
	endtask
	task automatic t_regs();
		chk(16'hf296, 8'h00);
		chk(16'hf292, 8'hff);
		chk(16'hf293, 8'h0f);
		chk(16'hf2a0, 8'h00);
		acc(1'b1, 16'hf292, 8'h05);
		chk(16'hf292, 8'h05);
		wr(16'hf293, 8'h00);
	endtask
	task automatic t_tx();
		wr(16'hf225, 8'h00);
		wr(16'hf224, 8'h0c);
		wr(16'hf223, 8'h08);
		wr(16'hf222, 8'h08);
		wr(16'hf221, 8'h04);
		wr(16'hf290, 8'h04);
		same(16'h0044, port4_oe, 8'h08);
		same(16'h0045, port4_out, 8'h08);
		acc(1'b1, 16'hf295, 8'ha5);
		chk(16'hf296, 8'h08);
		wr(16'hf294, 8'h01);
		wait_irq(t[0]);
		chk(16'hf296, 8'h00);
		acc(1'b1, 16'hf295, 8'h3c);
		chk(16'hf296, 8'h08);
		wait_irq(t[1]);
		wait_irq(t[2]);
		same(16'h0090, 8'(t[1] - t[0]), 8'h5a);
		same(16'h0091, 8'(t[2] - t[1]), 8'h5a);
		chk(16'hf294, 8'h00);
		same(16'h0092, utx_peer_inst.got[0], 8'ha5);
		same(16'h0093, utx_peer_inst.got[1], 8'h3c);
	endtask
	task automatic t_rx();
		wr(16'hf290, 8'h05);
		wr(16'hf294, 8'h01);
		same(16'h0043, {7'h00, port4_out[3]}, 8'h01);
		rx_frame(11'h15a, 9);
		chk(16'hf295, 8'h5a);
		chk(16'hf296, 8'h00);
		rx_frame(11'h0c3, 9);
		rx_frame(11'h10f, 9);
		chk(16'hf296, 8'h03);
		chk(16'hf295, 8'h0f);
		acc(1'b1, 16'hf296, 8'h5a);
		chk(16'hf296, 8'h00);
		wr(16'hf294, 8'h00);
		wr(16'hf291, 8'h04);
		wr(16'hf290, 8'h15);
		on_p4 <= 1'b1;
		wr(16'hf294, 8'h01);
		rx_frame(11'h381, 10);
		chk(16'hf296, 8'h04);
		chk(16'hf295, 8'h81);
		wr(16'hf291, 8'h21);
		rx_frame(11'h0d6, 8);
		chk(16'hf295, 8'h35);
	endtask
	task automatic close_out();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		on_p4 = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_tx();
		t_rx();
		close_out();
	end
endmodule // testbench

// ===== verification/utx_engine_checker.sv
// Port assertions of the serial channel.
`timescale 1ns/1ns
module utx_engine_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Pins and event
	input wire logic [7:0]  port4_out,
	input wire logic        serial_irq
);
	logic [2:0] cfg;
	logic       rt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Mode and tx pin function are shadowed from writes; the ports do not show them.
	always_ff @(posedge clk)
		if (!rst_n)
			cfg <= 3'h0;
		else if (reg_wr && reg_addr == 16'hf290)
			cfg[0] <= reg_wdata[0];
		else if (reg_wr && reg_addr == 16'hf224)
			cfg[1] <= reg_wdata[3];
		else if (reg_wr && reg_addr == 16'hf225)
			cfg[2] <= reg_wdata[3];
	assign rt = cfg[1] && !cfg[2];
	a_irq_pulse: assert property (serial_irq |=> !serial_irq [*8])
		else $error("irq too close");
	a_full_set: assert property (reg_wr && reg_addr == 16'hf295 && !cfg[0] ##1
		reg_rd && reg_addr == 16'hf296 |=> reg_rdata[3]) else $error("full not set");
	a_tx_high: assert property (cfg[0] && rt && $past(cfg[0] && rt) |-> port4_out[3])
		else $error("tx pin not high");
	a_stat_clear: assert property ($past(reg_wr && reg_addr == 16'hf296) && reg_rd &&
		reg_addr == 16'hf296 && !serial_irq && !$past(serial_irq) |=> reg_rdata == 8'h00)
		else $error("status not cleared");
	a_tx_noerr: assert property (!cfg[0] && $past(reg_rd && reg_addr == 16'hf296) |->
		reg_rdata[2:0] == 3'h0) else $error("error flag in transmit");
	a_rx_nofull: assert property (cfg[0] && $past(cfg[0] && reg_rd && reg_addr == 16'hf296)
		|-> !reg_rdata[3]) else $error("full in receive");
	a_baud_high: assert property ($past(reg_rd && reg_addr == 16'hf293) |->
		reg_rdata[7:4] == 4'h0) else $error("baud high spare bits");
	a_baud_back: assert property (reg_wr && reg_addr == 16'hf292 ##1 reg_rd &&
		reg_addr == 16'hf292 |=> reg_rdata == $past(reg_wdata, 2)) else $error("baud readback");
endmodule // utx_engine_checker
bind utx_engine utx_engine_checker utx_engine_checker_inst (.clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port4_out, .serial_irq);

// ===== verification/utx_peer.sv
// Remote serial peer that frames bits onto its line and decodes the device's line.
`timescale 1ns/1ns
module utx_peer #(
	parameter int BIT = 9
) (
	// Clock
	input  wire logic clk,
	// Line
	input  wire logic rx_line,
	output logic      tx_line
);
	logic [7:0] got [$];
	logic [7:0] sh;
	initial
		tx_line = 1'b1;
	task automatic send(input logic [10:0] b, input int n);
		tx_line <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			tx_line <= b[i];
			repeat (BIT) @(posedge clk);
		end
		// A full idle bit keeps a bad stop from hiding the next start edge.
		tx_line <= 1'b1;
		repeat (BIT) @(posedge clk);
	endtask
	initial
		forever
		begin
			@(negedge rx_line);
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clk);
				sh[i] = rx_line;
			end
			got.push_back(sh);
			repeat (BIT) @(posedge clk);
		end
endmodule // utx_peer
